// [gp6_port.v]
// Implementation choices: the address map and register access over AXI4-Lite.
`include "gp6_defs.vh"
`default_nettype none

// Function
// - six two-way pins; direction bit one puts driver in high impedance
// - direction bit zero enables driver and drives the output latch bit
// - port register reads pin levels; writes go into the output latch
// - port writes sample pins, merge written data, store into latch
// - latch keeps whichever of latch or port write came last
// - direction bits gate drivers even for analog pins
// - analog-selected pins read as zero digitally
// - analog select never changes digital output drive
// - analog select bits reset to analog; software clears them
// - threshold bit one picks schmitt input, zero picks ttl input
// - open-drain bit one sinks only; zero is push-pull
// - i2c ownership forces open-drain without the open-drain bit
// - slew bit one limits slew; zero drives at full rate
// - one weak pull-up enable bit per pin in its own register
// - after reset the latch is the output source; pin-select picks others
// - port register holds pins in bits 5..0; bits 7..6 read zero
// - pull-up off for outputs, except open-drain while driving high

module gp6_port (
    input wire aclk,                  // system clock, 25 MHz
    input wire aresetn,               // synchronous reset, active low
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,    // write byte address
    input wire [2:0] s_axi_awprot,    // protection, unused
    input wire s_axi_awvalid,         // write address valid
    output reg s_axi_awready,         // write address ready
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,    // write data
    input wire [3:0] s_axi_wstrb,     // byte enables
    input wire s_axi_wvalid,          // write data valid
    output reg s_axi_wready,          // write data ready
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,     // write response
    output reg s_axi_bvalid,          // write response valid
    input wire s_axi_bready,          // write response ready
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,    // read byte address
    input wire [2:0] s_axi_arprot,    // protection, unused
    input wire s_axi_arvalid,         // read address valid
    output reg s_axi_arready,         // read address ready
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,    // read data
    output reg [1:0] s_axi_rresp,     // read response
    output reg s_axi_rvalid,          // read data valid
    input wire s_axi_rready,          // read data ready
    // pads
    input wire [5:0] pin_levels_ttl,  // pad levels through ttl receivers
    input wire [5:0] pin_levels_st,   // pad levels through schmitt receivers
    output wire [5:0] pin_levels_o,   // pad output levels
    output wire [5:0] pin_levels_oe,  // pad driver enables, high = driving
    output wire [5:0] pullup_on,      // weak pull-ups switched on
    output wire [5:0] slew_limited,   // slew-limited drive per pad
    // peripheral pin-select side
    input wire [5:0] alt_sel,         // peripheral output chosen per pin
    input wire [5:0] alt_out,         // peripheral output values
    input wire [5:0] i2c_own,         // i2c peripheral owns the pin
    output reg [5:0] pin_din_q        // digital input levels for peripherals and change detect
);

// --------------------------------------------------------------------
// registers and wires
// --------------------------------------------------------------------
reg [5:0] pin_direction_bits_q;
reg [5:0] output_latch_bits_q;
reg [5:0] analog_select_bits_q;
reg [5:0] pullup_enable_bits_q;
reg [5:0] open_drain_bits_q;
reg [5:0] slew_limit_bits_q;
reg [5:0] input_threshold_bits_q;
reg [5:0] wr_idx_q;
reg [31:0] wr_data_q;
reg [3:0] wr_strb_q;
reg [5:0] lat_d;
reg [31:0] rd_word;
reg rd_ok;
reg wr_ok;
wire [5:0] ttl_s;
wire [5:0] st_s;
wire [5:0] pin_levels;
wire [5:0] port_merge;
wire wr_go;

// --------------------------------------------------------------------
// pad input path
// --------------------------------------------------------------------

// both receiver outputs come from the pads and must be synchronised
gp6_sync #(
    .WIDTH(6)
) u_sync_ttl (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(pin_levels_ttl),
    .sync_q(ttl_s)
);

gp6_sync #(
    .WIDTH(6)
) u_sync_st (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(pin_levels_st),
    .sync_q(st_s)
);

// threshold selection then analog gating of the digital buffer
assign pin_levels = (input_threshold_bits_q & st_s | ~input_threshold_bits_q & ttl_s)
    & ~analog_select_bits_q;

// digital level to peripherals and change detection uses the same threshold
always @(posedge aclk) begin
    if (!aresetn) begin
        pin_din_q <= 6'h00;
    end else begin
        pin_din_q <= pin_levels;
    end
end

// --------------------------------------------------------------------
// pad drive stages
// --------------------------------------------------------------------

// one drive stage per pin; analog select is deliberately not an input
genvar gi;
generate
    for (gi = 0; gi < `GP6_PINS; gi = gi + 1) begin : g_pin
        gp6_pin u_pin (
            .aclk(aclk),
            .aresetn(aresetn),
            .dir_in(pin_direction_bits_q[gi]),
            .lat(output_latch_bits_q[gi]),
            .od(open_drain_bits_q[gi]),
            .i2c_own(i2c_own[gi]),
            .alt_sel(alt_sel[gi]),
            .alt_out(alt_out[gi]),
            .wpu(pullup_enable_bits_q[gi]),
            .slew(slew_limit_bits_q[gi]),
            .pad_out_q(pin_levels_o[gi]),
            .pad_oe_q(pin_levels_oe[gi]),
            .pullup_q(pullup_on[gi]),
            .slew_q(slew_limited[gi])
        );
    end
endgenerate

// --------------------------------------------------------------------
// write channel handshake
// --------------------------------------------------------------------

// a write runs once address and data are both held and no response waits
assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

// address and data are taken independently, in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `GP6_RESP_OKAY;
        wr_idx_q <= 6'h00;
        wr_data_q <= 32'h00000000;
        wr_strb_q <= 4'h0;
    end else begin
        if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            wr_idx_q <= s_axi_awaddr[7:2];
        end
        if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            wr_data_q <= s_axi_wdata;
            wr_strb_q <= s_axi_wstrb;
        end
        if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `GP6_RESP_OKAY : `GP6_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// --------------------------------------------------------------------
// register writes
// --------------------------------------------------------------------

// sampled pins merged with the written byte where its lane is enabled
assign port_merge = wr_strb_q[0] ? wr_data_q[5:0] : pin_levels;

// address decode and next latch value
always @* begin
    wr_ok = (wr_idx_q <= `GP6_IDX_THR);
    lat_d = output_latch_bits_q;
    if (wr_idx_q == `GP6_IDX_PORT) begin
        lat_d = port_merge;
    end else if (wr_idx_q == `GP6_IDX_LAT && wr_strb_q[0]) begin
        lat_d = wr_data_q[5:0];
    end
end

// configuration registers; only byte lane 0 carries bits
always @(posedge aclk) begin
    if (!aresetn) begin
        pin_direction_bits_q <= `GP6_RST_DIR;
        output_latch_bits_q <= `GP6_RST_LAT;
        analog_select_bits_q <= `GP6_RST_ANA;
        pullup_enable_bits_q <= `GP6_RST_WPU;
        open_drain_bits_q <= `GP6_RST_ODC;
        slew_limit_bits_q <= `GP6_RST_SLR;
        input_threshold_bits_q <= `GP6_RST_THR;
    end else if (wr_go) begin
        output_latch_bits_q <= lat_d;
        if (wr_strb_q[0]) begin
            case (wr_idx_q)
                `GP6_IDX_DIR: begin
                    pin_direction_bits_q <= wr_data_q[5:0];
                end
                `GP6_IDX_ANA: begin
                    analog_select_bits_q <= wr_data_q[5:0];
                end
                `GP6_IDX_WPU: begin
                    pullup_enable_bits_q <= wr_data_q[5:0];
                end
                `GP6_IDX_ODC: begin
                    open_drain_bits_q <= wr_data_q[5:0];
                end
                `GP6_IDX_SLR: begin
                    slew_limit_bits_q <= wr_data_q[5:0];
                end
                `GP6_IDX_THR: begin
                    input_threshold_bits_q <= wr_data_q[5:0];
                end
                default: begin
                end
            endcase
        end
    end
end

// --------------------------------------------------------------------
// register reads
// --------------------------------------------------------------------

// read decode; upper bits of every register read as zero
always @* begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr[7:2])
        `GP6_IDX_PORT: begin
            rd_word[5:0] = pin_levels;
        end
        `GP6_IDX_DIR: begin
            rd_word[5:0] = pin_direction_bits_q;
        end
        `GP6_IDX_LAT: begin
            rd_word[5:0] = output_latch_bits_q;
        end
        `GP6_IDX_ANA: begin
            rd_word[5:0] = analog_select_bits_q;
        end
        `GP6_IDX_WPU: begin
            rd_word[5:0] = pullup_enable_bits_q;
        end
        `GP6_IDX_ODC: begin
            rd_word[5:0] = open_drain_bits_q;
        end
        `GP6_IDX_SLR: begin
            rd_word[5:0] = slew_limit_bits_q;
        end
        `GP6_IDX_THR: begin
            rd_word[5:0] = input_threshold_bits_q;
        end
        default: begin
            rd_ok = 1'b0;
        end
    endcase
end

// read channel: data one cycle after the address is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `GP6_RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `GP6_RESP_OKAY : `GP6_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

endmodule

`default_nettype wire

// [gp6_defs.vh]
`ifndef GP6_DEFS_VH
`define GP6_DEFS_VH

// port geometry
`define GP6_PINS 6
`define GP6_REG_W 8

// byte addresses of the registers
`define GP6_ADDR_PORT 8'h00
`define GP6_ADDR_DIR 8'h04
`define GP6_ADDR_LAT 8'h08
`define GP6_ADDR_ANA 8'h0c
`define GP6_ADDR_WPU 8'h10
`define GP6_ADDR_ODC 8'h14
`define GP6_ADDR_SLR 8'h18
`define GP6_ADDR_THR 8'h1c

// word indices (address bits 7:2)
`define GP6_IDX_PORT 6'h00
`define GP6_IDX_DIR 6'h01
`define GP6_IDX_LAT 6'h02
`define GP6_IDX_ANA 6'h03
`define GP6_IDX_WPU 6'h04
`define GP6_IDX_ODC 6'h05
`define GP6_IDX_SLR 6'h06
`define GP6_IDX_THR 6'h07

// reset values
`define GP6_RST_DIR 6'h3f
`define GP6_RST_LAT 6'h00
`define GP6_RST_ANA 6'h3f
`define GP6_RST_WPU 6'h00
`define GP6_RST_ODC 6'h00
`define GP6_RST_SLR 6'h3f
`define GP6_RST_THR 6'h3f

// bus answers
`define GP6_RESP_OKAY 2'h0
`define GP6_RESP_SLVERR 2'h2

`endif

// [gp6_sync.v]
`default_nettype none

// --------------------------------------------------------------------
// two-stage synchroniser for asynchronous pad levels
// --------------------------------------------------------------------
module gp6_sync #(
    parameter WIDTH = 6
) (
    input wire aclk,                 // system clock
    input wire aresetn,              // synchronous reset, active low
    input wire [WIDTH-1:0] async_i,  // level from outside the clock domain
    output reg [WIDTH-1:0] sync_q    // level safe to use
);

reg [WIDTH-1:0] meta_q;

// first stage is read only by the second stage
always @(posedge aclk) begin
    if (!aresetn) begin
        meta_q <= {WIDTH{1'b0}};
        sync_q <= {WIDTH{1'b0}};
    end else begin
        meta_q <= async_i;
        sync_q <= meta_q;
    end
end

endmodule

`default_nettype wire

// [gp6_pin.v]
`default_nettype none

// --------------------------------------------------------------------
// drive stage of one pad: output source, drive mode, pull-up, slew
// --------------------------------------------------------------------
module gp6_pin (
    input wire aclk,        // system clock
    input wire aresetn,     // synchronous reset, active low
    input wire dir_in,      // direction bit, 1 = input
    input wire lat,         // output latch bit
    input wire od,          // open-drain bit
    input wire i2c_own,     // i2c peripheral owns the pin
    input wire alt_sel,     // pin-select chose a peripheral output
    input wire alt_out,     // peripheral output value
    input wire wpu,         // pull-up enable bit
    input wire slew,        // slew-limit bit
    output reg pad_out_q,   // level driven onto the pad
    output reg pad_oe_q,    // pad driver enabled, active high
    output reg pullup_q,    // weak pull-up switched on
    output reg slew_q       // slew-limited drive selected
);

wire src;
wire od_eff;
wire drive;

// latch is the source unless pin-select picked a peripheral; analog select plays no part
assign src = alt_sel ? alt_out : lat;
// i2c forces open-drain whatever the open-drain bit says
assign od_eff = od | i2c_own;
// direction gates the driver; open-drain only ever sinks
assign drive = ~dir_in & (~od_eff | ~src);

// registered pad controls
always @(posedge aclk) begin
    if (!aresetn) begin
        pad_out_q <= 1'b0;
        pad_oe_q <= 1'b0;
        pullup_q <= 1'b0;
        slew_q <= 1'b1;
    end else begin
        pad_out_q <= od_eff ? 1'b0 : src;
        pad_oe_q <= drive;
        pullup_q <= wpu & (dir_in | (od_eff & src));
        slew_q <= slew;
    end
end

endmodule

`default_nettype wire

// [gp6_port_checker.sv]
`default_nettype none
// ----------------------------------------
// bus and pad checker
// ----------------------------------------
module gp6_port_checker (
    input wire logic aclk,                  // clock
    input wire logic aresetn,               // reset, low
    input wire logic s_axi_awvalid,         // aw valid
    input wire logic s_axi_awready,         // aw ready
    input wire logic s_axi_wvalid,          // w valid
    input wire logic s_axi_wready,          // w ready
    input wire logic [1:0] s_axi_bresp,     // b code
    input wire logic s_axi_bvalid,          // b valid
    input wire logic s_axi_bready,          // b ready
    input wire logic s_axi_arvalid,         // ar valid
    input wire logic s_axi_arready,         // ar ready
    input wire logic [31:0] s_axi_rdata,    // r data
    input wire logic s_axi_rvalid,          // r valid
    input wire logic s_axi_rready,          // r ready
    input wire logic [5:0] pin_levels_o,    // pad level
    input wire logic [5:0] pin_levels_oe,   // pad enable
    input wire logic [5:0] pullup_on,       // pull-ups
    input wire logic [5:0] slew_limited,    // slew mode
    input wire logic [5:0] alt_sel,         // peripheral pick
    input wire logic [5:0] alt_out,         // peripheral level
    input wire logic [5:0] i2c_own          // i2c owner
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain for every property
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a write is taken whole, then answered two edges later
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_awready ##1 s_axi_bvalid;
    endsequence
    property p_wr_resp;
        s_wr_take |=> s_wr_answer;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_upper;
        s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0;
    endproperty
    // reset leaves every pad an undriven, slew-limited input
    property p_reset;
        disable iff (1'h0) !aresetn |=> pin_levels_oe == 6'h00 && slew_limited == 6'h3f && pullup_on == 6'h00;
    endproperty
    property p_i2c_od;
        (pin_levels_o & $past(i2c_own)) == 6'h00;
    endproperty
    property p_alt_src;
        (pin_levels_oe & $past(alt_sel) & (pin_levels_o ^ $past(alt_out))) == 6'h00;
    endproperty
    property p_pull_off;
        (pin_levels_oe & pullup_on) == 6'h00;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    a_reset: assert property (p_reset) else $error("pad reset state wrong");
    a_i2c_od: assert property (p_i2c_od) else $error("i2c pin drives high");
    a_alt_src: assert property (p_alt_src) else $error("peripheral level not driven");
    a_pull_off: assert property (p_pull_off) else $error("pull-up on driven pad");
endmodule

bind gp6_port gp6_port_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_levels_o, .pin_levels_oe, .pullup_on,
    .slew_limited, .alt_sel, .alt_out, .i2c_own);
`default_nettype wire

// [gp6_pads.sv]
`default_nettype none
// ----------------------------------------
// outside pads and their two receivers
// ----------------------------------------
module gp6_pads (
    input wire logic [5:0] pad_o,    // driven level
    input wire logic [5:0] pad_oe,   // driver enable
    input wire logic [5:0] pull,     // weak pull-up on
    input wire logic [5:0] ext,      // outside source
    input wire logic [5:0] skew,     // pins where receivers disagree
    output logic [5:0] ttl,          // ttl receiver
    output logic [5:0] st            // schmitt receiver
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lvl;
    // driver wins, else pull-up, else the outside source
    assign lvl = (pad_oe & pad_o) | (~pad_oe & (pull | ext));
    assign ttl = lvl;
    assign st = lvl ^ skew;
endmodule
`default_nettype wire

// [testbench.sv]
`include "gp6_defs.vh"
`default_nettype none
// ----------------------------------------
// register and pad bench
// ----------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] ext = 6'h00, skew = 6'h00, alt_sel = 6'h00, alt_out = 6'h00, i2c = 6'h00;
    logic [5:0] ttl, st, p_o, p_oe, pu, slew, din, e_o, e_oe, e_pu, e_rd;
    logic [5:0] m [8];
    logic [31:0] seed = 32'h783c;
    int miscompares = 0, tests_run = 0, cycles = 0;

    gp6_port uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_levels_ttl(ttl), .pin_levels_st(st), .pin_levels_o(p_o),
        .pin_levels_oe(p_oe), .pullup_on(pu), .slew_limited(slew), .alt_sel, .alt_out, .i2c_own(i2c),
        .pin_din_q(din));
    gp6_pads pads (.pad_o(p_o), .pad_oe(p_oe), .pull(pu), .ext, .skew, .ttl, .st);

    // clock and hang guard
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // bus master: hold each channel until taken, answer may be accepted late
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'(rnd());
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
                s_axi_bready <= 1'h1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'(rnd());
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                s_axi_rready <= 1'h1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // let pads settle, then work out what they should show
    task automatic calc();
        logic [5:0] src, od;
        repeat (4) @(posedge aclk);
        src = (alt_sel & alt_out) | (~alt_sel & m[2]);
        od = m[5] | i2c;
        e_oe = ~m[1] & (~od | ~src);
        e_o = ~od & src;
        e_pu = m[4] & (m[1] | (od & src));
        e_rd = ~m[3] & (((e_oe & e_o) | (~e_oe & (e_pu | ext))) ^ (m[7] & skew));
    endtask

    task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        calc();
        axi_write(8'(i * 4), d, s, r);
        check("bresp", r, i < 8 ? `GP6_RESP_OKAY : `GP6_RESP_SLVERR);
        if (i < 8 && (s[0] || i == 0))
            m[i == 0 ? 2 : i] = s[0] ? d[5:0] : e_rd;
    endtask

    task automatic rd(input int i);
        logic [31:0] d;
        logic [1:0] r;
        calc();
        axi_read(8'(i * 4), d, r);
        check("rresp", r, i < 8 ? `GP6_RESP_OKAY : `GP6_RESP_SLVERR);
        check("rdata", d, i == 0 ? e_rd : i < 8 ? m[i] : 6'h00);
    endtask

    task automatic check_pads();
        calc();
        check("pad oe", p_oe, e_oe);
        check("pad out", p_o, e_o);
        check("pullup", pu, e_pu);
        check("slew", slew, m[6]);
        check("din", din, e_rd);
    endtask

    // hold reset for 20 cycles, then every register must read its reset value and every pad must match the model
    task automatic do_reset();
        aresetn <= 1'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        ext <= 6'(rnd());
        m = '{6'h00, `GP6_RST_DIR, `GP6_RST_LAT, `GP6_RST_ANA, `GP6_RST_WPU, `GP6_RST_ODC, `GP6_RST_SLR,
            `GP6_RST_THR};
        for (int i = 0; i < 9; i++)
            rd(i);
        check_pads();
        $display("test reset values done");
    endtask

    // reset values, then random configurations and pad traffic, then a second reset at the end of the run
    initial begin
        int k;
        do_reset();
        for (int n = 0; n < 24; n++) begin
            // thresholds move only while no peripheral uses a pin
            alt_sel <= 6'h00;
            i2c <= 6'h00;
            wr(7, rnd(), 4'h1);
            ext <= 6'(rnd());
            skew <= 6'(rnd());
            alt_sel <= 6'(rnd());
            alt_out <= 6'(rnd());
            i2c <= 6'(rnd() & rnd());
            // random writes leave the threshold register alone while peripherals run
            repeat (6) begin
                k = int'(rnd() % 9);
                wr(k == 7 ? 8 : k, rnd(), 4'(rnd()));
            end
            check_pads();
            for (int i = 0; i < 9; i++)
                rd(i);
        end
        $display("test random traffic done");
        do_reset();
        stop_test();
    end
endmodule
`default_nettype wire
